// *** table_read_transfer_ops.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "table_ops_regs.svh"
module table_read_transfer_ops
  import table_ops_pkg::*;
#(
  parameter int PC_W = 12,
  parameter int SP_W = 3,
  parameter logic [9:0] SPLIT_CODE = `TBL_SPLIT_CODE,
  parameter logic [9:0] PTR_CODE = `TBL_PTR_CODE
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [9:0] instr_i,
  input wire logic [7:0] ext_reg_i,
  input wire logic [2:0] table_pointer_register_i,
  input wire logic [3:0] acc_in_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [SP_W-1:0] stack_pointer_i,
  input wire logic [9:0] rom_data_i,
  output logic [3:0] acc_o,
  output logic [3:0] reg_b_o,
  output logic acc_we_o,
  output logic reg_b_we_o,
  output logic busy_o,
  output logic [PC_W-1:0] rom_addr_o,
  output logic rom_rd_o,
  output logic [SP_W-1:0] stack_pointer_o,
  output logic stack_pointer_we_o,
  output logic [SP_W-1:0] return_stack_addr_o,
  output logic [PC_W-1:0] return_stack_wdata_o,
  output logic return_stack_we_o,
  output logic [PC_W-1:0] pc_o,
  output logic pc_we_o
);
  localparam int PAGE_W = `TBL_PAGE_HI - `TBL_PAGE_LO + 1;
  localparam int INPAGE_W = PC_W - PAGE_W;

  // Refuse widths and codes that the decode and address paths cannot serve
  if (INPAGE_W != `TBL_INPAGE_W) begin : g_bad_pc_w
    $error("table_read_transfer_ops: PC_W must be the page bits plus the in-page bits");
  end
  if (SP_W < 1) begin : g_bad_sp_w
    $error("table_read_transfer_ops: SP_W must be at least one");
  end
  if (SPLIT_CODE == PTR_CODE) begin : g_same_codes
    $error("table_read_transfer_ops: split and pointer codes must differ");
  end
  if (SPLIT_CODE[`TBL_OPC_HI:`TBL_OPC_LO] == `TBL_OPC_VAL) begin : g_split_in_table
    $error("table_read_transfer_ops: split code falls inside the table read range");
  end
  if (PTR_CODE[`TBL_OPC_HI:`TBL_OPC_LO] == `TBL_OPC_VAL) begin : g_ptr_in_table
    $error("table_read_transfer_ops: pointer code falls inside the table read range");
  end

  tbl_state_e state;
  logic [PC_W-1:0] saved_pc;
  logic [SP_W-1:0] sp_up;
  logic [SP_W-1:0] sp_down;
  logic [PC_W-1:0] jump_addr;
  logic [3:0] rom_hi;
  logic [3:0] rom_lo;
  logic [3:0] ext_hi;
  logic [3:0] ext_lo;
  logic is_table;
  logic is_split;
  logic is_ptr;
  logic take_table;
  logic take_split;
  logic take_ptr;

  // Decode; only an idle sequencer takes a new instruction
  assign is_table = instr_valid_i && instr_i[`TBL_OPC_HI:`TBL_OPC_LO] == `TBL_OPC_VAL;
  assign is_split = instr_valid_i && instr_i == SPLIT_CODE;
  assign is_ptr = instr_valid_i && instr_i == PTR_CODE;
  assign take_table = state == ST_IDLE && is_table;
  assign take_split = state == ST_IDLE && !is_table && is_split;
  assign take_ptr = state == ST_IDLE && !is_table && !is_split && is_ptr;
  assign sp_up = stack_pointer_i + SP_W'(1);
  assign sp_down = stack_pointer_i - SP_W'(1);
  assign jump_addr = PC_W'({instr_i[`TBL_PAGE_HI:`TBL_PAGE_LO], table_pointer_register_i, acc_in_i});

  // Program memory word into B and A halves
  nibble_split u_rom_split (
    .word_i(rom_data_i[`TBL_ROM_B_HI:`TBL_ROM_A_LO]),
    .high_o(rom_hi),
    .low_o(rom_lo)
  );

  // Extension register into B and A halves
  nibble_split u_ext_split (
    .word_i(ext_reg_i[`TBL_EXT_B_HI:`TBL_EXT_A_LO]),
    .high_o(ext_hi),
    .low_o(ext_lo)
  );

  // Sequencer for the table read
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      saved_pc <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (is_table) begin
            state <= ST_FETCH;
            saved_pc <= pc_i;
          end
        end
        ST_FETCH: state <= ST_RETURN;
        ST_RETURN: state <= ST_IDLE;
      endcase
    end
  end

  // Stack pointer: up on the push, back down on the return
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stack_pointer_o <= '0;
      stack_pointer_we_o <= 1'b0;
    end else begin
      stack_pointer_we_o <= 1'b0;
      if (take_table) begin
        stack_pointer_o <= sp_up;
        stack_pointer_we_o <= 1'b1;
      end else if (state == ST_FETCH) begin
        stack_pointer_o <= sp_down;
        stack_pointer_we_o <= 1'b1;
      end
    end
  end

  // One stack level holds the address of the next instruction
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      return_stack_addr_o <= '0;
      return_stack_wdata_o <= '0;
      return_stack_we_o <= 1'b0;
    end else begin
      return_stack_we_o <= 1'b0;
      if (take_table) begin
        return_stack_addr_o <= sp_up;
        return_stack_wdata_o <= pc_i;
        return_stack_we_o <= 1'b1;
      end
    end
  end

  // Program counter: jump into the table, then restore
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_o <= '0;
      pc_we_o <= 1'b0;
    end else begin
      pc_we_o <= 1'b0;
      if (take_table) begin
        pc_o <= jump_addr;
        pc_we_o <= 1'b1;
      end else if (state == ST_FETCH) begin
        pc_o <= saved_pc;
        pc_we_o <= 1'b1;
      end
    end
  end

  // Program memory read strobe and address
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rom_addr_o <= '0;
      rom_rd_o <= 1'b0;
    end else begin
      rom_rd_o <= 1'b0;
      if (take_table) begin
        rom_addr_o <= jump_addr;
        rom_rd_o <= 1'b1;
      end
    end
  end

  // Busy covers the two cycles after a table read is taken
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= take_table || state == ST_FETCH;
    end
  end

  // Accumulator result
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_o <= `TBL_A_RESET;
      acc_we_o <= 1'b0;
    end else begin
      acc_we_o <= 1'b0;
      if (state == ST_FETCH) begin
        acc_o <= rom_lo;
        acc_we_o <= 1'b1;
      end else if (take_split) begin
        acc_o <= ext_lo;
        acc_we_o <= 1'b1;
      end else if (take_ptr) begin
        acc_o <= {1'b0, table_pointer_register_i};
        acc_we_o <= 1'b1;
      end
    end
  end

  // Register B result; the pointer op leaves B alone
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_b_o <= `TBL_B_RESET;
      reg_b_we_o <= 1'b0;
    end else begin
      reg_b_we_o <= 1'b0;
      if (state == ST_FETCH) begin
        reg_b_o <= rom_hi;
        reg_b_we_o <= 1'b1;
      end else if (take_split) begin
        reg_b_o <= ext_hi;
        reg_b_we_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** table_ops_regs.svh ***
`ifndef TABLE_OPS_REGS_SVH
`define TABLE_OPS_REGS_SVH
`define TBL_OPC_HI 9
`define TBL_OPC_LO 5
`define TBL_OPC_VAL 5'h04
`define TBL_PAGE_HI 4
`define TBL_PAGE_LO 0
`define TBL_ROM_B_HI 7
`define TBL_ROM_B_LO 4
`define TBL_ROM_A_HI 3
`define TBL_ROM_A_LO 0
`define TBL_EXT_B_HI 7
`define TBL_EXT_A_LO 0
`define TBL_INPAGE_W 7
`define TBL_SPLIT_CODE 10'h000
`define TBL_PTR_CODE 10'h051
`define TBL_A_RESET 4'h0
`define TBL_B_RESET 4'h0
`endif

// *** table_ops_pkg.sv ***
package table_ops_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RETURN} tbl_state_e;
  typedef logic [3:0] nibble_t;
endpackage

// *** nibble_split.sv ***
`timescale 1ns/1ps
`default_nettype none
module nibble_split (
  input wire logic [7:0] word_i,
  output logic [3:0] high_o,
  output logic [3:0] low_o
);
  assign high_o = word_i[7:4];
  assign low_o = word_i[3:0];
endmodule
`default_nettype wire

// *** table_ops_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module table_ops_checker #(parameter int PC_W = 12, SP_W = 3, parameter logic [9:0] SPLIT_CODE = 10'h000,
  PTR_CODE = 10'h051) (
  input wire logic ref_clk_i, resetn_i, instr_valid_i, busy_o, acc_we_o, reg_b_we_o, rom_rd_o, pc_we_o,
  input wire logic return_stack_we_o, stack_pointer_we_o,
  input wire logic [9:0] instr_i, rom_data_i,
  input wire logic [7:0] ext_reg_i,
  input wire logic [2:0] table_pointer_register_i,
  input wire logic [3:0] acc_in_i, acc_o, reg_b_o,
  input wire logic [PC_W-1:0] pc_i, rom_addr_o, return_stack_wdata_o, pc_o,
  input wire logic [SP_W-1:0] stack_pointer_i, stack_pointer_o, return_stack_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire go = instr_valid_i && !busy_o;
  wire tbl = go && instr_i[9:5] == 5'h04;
  chk_split_xfer: assert property (go && instr_i == SPLIT_CODE |=> acc_we_o && reg_b_we_o &&
    {reg_b_o, acc_o} == $past(ext_reg_i)) else $error("split");
  chk_ptr_xfer: assert property (go && instr_i == PTR_CODE |=> acc_we_o && !reg_b_we_o &&
    acc_o == {1'b0, $past(table_pointer_register_i)}) else $error("pointer");
  chk_tbl_jump: assert property (tbl |=> rom_rd_o && pc_we_o && pc_o == rom_addr_o &&
    rom_addr_o == {$past(instr_i[4:0]), $past(table_pointer_register_i), $past(acc_in_i)}) else $error("jump");
  chk_tbl_push: assert property (tbl |=> return_stack_we_o && return_stack_wdata_o == $past(pc_i) &&
    stack_pointer_we_o && stack_pointer_o == SP_W'($past(stack_pointer_i) + 1'b1) &&
    return_stack_addr_o == stack_pointer_o) else $error("push");
  chk_rom_load: assert property (rom_rd_o |=> acc_we_o && reg_b_we_o &&
    {reg_b_o, acc_o} == $past(rom_data_i[7:0])) else $error("load");
  chk_tbl_pop: assert property (rom_rd_o |=> pc_we_o && pc_o == $past(return_stack_wdata_o) &&
    stack_pointer_we_o && stack_pointer_o == SP_W'($past(stack_pointer_i) - 1'b1)) else $error("pop");
  chk_busy_span: assert property (tbl |=> busy_o [*2] ##1 !busy_o) else $error("busy");
  chk_quiet_end: assert property (rom_rd_o |=> ##1 !acc_we_o && !pc_we_o && !stack_pointer_we_o)
    else $error("quiet");
endmodule
bind table_read_transfer_ops table_ops_checker #(.PC_W(PC_W), .SP_W(SP_W), .SPLIT_CODE(SPLIT_CODE),
  .PTR_CODE(PTR_CODE)) table_ops_checker_i (.*);
`default_nettype wire

// *** rom_stack_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rom_stack_model (
  input wire logic ref_clk_i, resetn_i, rom_rd_o, stack_pointer_we_o,
  input wire logic [11:0] rom_addr_o,
  input wire logic [2:0] stack_pointer_o,
  output logic [9:0] rom_data_i,
  output logic [2:0] stack_pointer_i
);
  logic [2:0] sp;
  // Outside a read the bus shows the inverse word
  assign rom_data_i = (rom_addr_o[9:0] ^ 10'h0a5) ^ {10{!rom_rd_o}};
  assign stack_pointer_i = stack_pointer_we_o ? stack_pointer_o : sp;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) sp <= 3'h2;
    else sp <= stack_pointer_i;
  end
endmodule
`default_nettype wire

// *** table_read_transfer_ops_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module table_read_transfer_ops_tb;
  localparam logic [9:0] SPL = 10'h06a;
  logic ref_clk_i = 0, resetn_i = 0, instr_valid_i = 0, acc_we_o, reg_b_we_o, busy_o, rom_rd_o;
  logic stack_pointer_we_o, return_stack_we_o, pc_we_o;
  logic [9:0] instr_i = 0, rom_data_i;
  logic [7:0] ext_reg_i = 0;
  logic [2:0] table_pointer_register_i = 0, stack_pointer_i, stack_pointer_o, return_stack_addr_o;
  logic [3:0] acc_in_i = 0, acc_o, reg_b_o;
  logic [11:0] pc_i = 0, rom_addr_o, return_stack_wdata_o, pc_o;
  logic [31:0] r = 32'h269a;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  logic [8:0] q[$];
  int err_total = 0, compares = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  table_read_transfer_ops #(.SPLIT_CODE(SPL), .PTR_CODE(10'h051)) table_read_transfer_ops_i (.*);
  rom_stack_model rom_stack_model_i (.*);
  task automatic check(input logic [8:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) if (acc_we_o === 1'b1) begin
    if (q.size() == 0) check(9'h1ff, 9'h000);
    else check({reg_b_we_o, reg_b_we_o ? reg_b_o : 4'h0, acc_o}, q.pop_front());
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1;
    repeat (60) begin
      @(posedge ref_clk_i);
      r = lfsr(r);
      instr_valid_i <= 1;
      {ext_reg_i, table_pointer_register_i, acc_in_i, pc_i} <= r[26:0];
      case (r[29:28])
        2'h0: begin instr_i <= SPL; q.push_back({1'b1, r[26:19]}); end
        2'h1: begin instr_i <= 10'h051; q.push_back({6'h00, r[18:16]}); end
        default: begin
          instr_i <= {5'h04, r[31:27]};
          q.push_back({1'b1, {r[27], r[18:12]} ^ 8'ha5});
          repeat (2) @(posedge ref_clk_i) instr_i <= SPL;
        end
      endcase
    end
    @(posedge ref_clk_i) instr_valid_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    check(9'(q.size()), 9'h000);
    $display("test random_ops done");
    stop_test();
  end
  initial begin
    #4000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
